// [bro_pkg.sv]
/*
  Shared constants of the barometer result readout: register indices,
  status field positions, widths and reset values.
  Assumes a bus with 32-bit words, where byte address = index * 4.
*/
package bro_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int BRO_PRESS_W = 24;
  localparam int BRO_TEMP_W = 16;
  localparam int BRO_OFFS_W = 16;
  localparam int BRO_IDX_W = 7;
  localparam int BRO_ADR_W = 9;

  // ****************************************************************
  // register indices
  // ****************************************************************
  localparam logic [6:0] BRO_IDX_OFFS_LO = 7'h18;
  localparam logic [6:0] BRO_IDX_OFFS_HI = 7'h19;
  localparam logic [6:0] BRO_IDX_STATUS = 7'h27;
  localparam logic [6:0] BRO_IDX_PRESS_LO = 7'h28;
  localparam logic [6:0] BRO_IDX_PRESS_MID = 7'h29;
  localparam logic [6:0] BRO_IDX_PRESS_HI = 7'h2A;
  localparam logic [6:0] BRO_IDX_TEMP_LO = 7'h2B;
  localparam logic [6:0] BRO_IDX_TEMP_HI = 7'h2C;
  localparam logic [6:0] BRO_IDX_LPF_RES = 7'h3C;
  localparam logic [6:0] BRO_IDX_MODE = 7'h40;
  localparam logic [6:0] BRO_IDX_IRQ_STAT = 7'h41;
  localparam logic [6:0] BRO_IDX_IRQ_MASK = 7'h42;
  localparam logic [6:0] BRO_IDX_QP_LO = 7'h78;
  localparam logic [6:0] BRO_IDX_QP_MID = 7'h79;
  localparam logic [6:0] BRO_IDX_QP_HI = 7'h7A;
  localparam logic [6:0] BRO_IDX_QT_LO = 7'h7B;
  localparam logic [6:0] BRO_IDX_QT_HI = 7'h7C;

  // ****************************************************************
  // status / interrupt field positions (shared layout)
  // ****************************************************************
  localparam int BRO_BIT_P_AVAIL = 0;
  localparam int BRO_BIT_T_AVAIL = 1;
  localparam int BRO_BIT_P_OVR = 4;
  localparam int BRO_BIT_T_OVR = 5;

  // mode register fields
  localparam int BRO_BIT_DIFF = 0;
  localparam int BRO_BIT_AZERO = 1;
  localparam int BRO_BIT_AREF = 2;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] BRO_RST_BYTE = 8'h00;
  localparam logic [31:0] BRO_RST_WORD = 32'h0000_0000;

endpackage : bro_pkg

// [bro_readout.sv]
/*
  Result and status register group of a barometer: conversion results,
  available / overrun flags, calibration offset, filter reset strobe,
  queued sample bytes and an interrupt, reached over classic Wishbone.
  Assumes conversion strobes and queue inputs are synchronous to sys_clk
  and that one register of 8 bits sits in the low byte of each word.
*/

// Operation
// - temperature overrun, status bit 5, sets when unread result is replaced
// - pressure overrun, status bit 4, sets when unread result is replaced
// - temperature available, status bit 1, sets on new result, else zero
// - pressure available, status bit 0, sets on new result, else zero
// - status reflects flags refreshed with every new conversion
// - pressure is 24-bit two's complement at 28h, 29h, 2Ah
// - with modes off, pressure equals measured minus signed offset 18h/19h
// - temperature is 16-bit two's complement at 2Bh and 2Ch
// - reading 3Ch resets the pressure smoothing filter
// - queued pressure sample bytes at 78h, 79h, 7Ah
// - queued temperature sample bytes at 7Bh, 7Ch, read-only
// - calibration offset is a 16-bit signed quantity
// - queued bytes readable singly or as a sequence of reads
module bro_readout
  import bro_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [23:0] pressure_measured,
  input wire logic pressure_valid,
  input wire logic [15:0] temperature_measured,
  input wire logic temperature_valid,
  input wire logic [23:0] queue_pressure,
  input wire logic [15:0] queue_temperature,
  input wire logic queue_not_empty,
  output logic queue_pop,
  output logic filter_reset,
  output logic irq
);

  // ****************************************************************
  // bus request decode
  // ****************************************************************
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic req;
  logic rd;
  logic wr;
  logic [BRO_IDX_W-1:0] idx;
  logic aligned;

  assign aligned = (wb_adr_i[1:0] == 2'h0);
  assign idx = wb_adr_i[8:2];
  assign req = wb_cyc_i & wb_stb_i & ~ack_q & aligned;
  assign rd = req & ~wb_we_i;
  // only the offset, mode and mask indices decode a write; all else drops
  assign wr = req & wb_we_i & wb_sel_i[0];

  // ****************************************************************
  // result channels
  // ****************************************************************
  bro_slot_if #(.W(BRO_PRESS_W)) p_if ();
  bro_slot_if #(.W(BRO_TEMP_W)) t_if ();

  bro_result_slot #(.W(BRO_PRESS_W)) u_press (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .port(p_if.slot)
  );

  bro_result_slot #(.W(BRO_TEMP_W)) u_temp (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .port(t_if.slot)
  );

  // ****************************************************************
  // calibration offset and mode control
  // ****************************************************************
  logic [7:0] offs_lo_q, offs_lo_d;
  logic [7:0] offs_hi_q, offs_hi_d;
  logic [2:0] mode_q, mode_d;
  logic [BRO_OFFS_W-1:0] calibration_offset;
  logic [BRO_PRESS_W-1:0] offset_ext;
  logic modes_off;

  assign calibration_offset = {offs_hi_q, offs_lo_q};
  // sign extension keeps the offset a two's complement quantity
  assign offset_ext = {{(BRO_PRESS_W - BRO_OFFS_W){calibration_offset[15]}},
                       calibration_offset};
  assign modes_off = (mode_q == 3'h0);

  always_comb begin
    offs_lo_d = offs_lo_q;
    offs_hi_d = offs_hi_q;
    mode_d = mode_q;
    if (wr && idx == BRO_IDX_OFFS_LO) begin
      offs_lo_d = wb_dat_i[7:0];
    end
    if (wr && idx == BRO_IDX_OFFS_HI) begin
      offs_hi_d = wb_dat_i[7:0];
    end
    if (wr && idx == BRO_IDX_MODE) begin
      mode_d = wb_dat_i[2:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      offs_lo_q <= BRO_RST_BYTE;
      offs_hi_q <= BRO_RST_BYTE;
      mode_q <= 3'h0;
    end else begin
      offs_lo_q <= offs_lo_d;
      offs_hi_q <= offs_hi_d;
      mode_q <= mode_d;
    end
  end

  // the other modes are handled elsewhere; here they pass raw pressure
  assign p_if.new_value = modes_off ? (pressure_measured - offset_ext)
                                    : pressure_measured;
  assign p_if.new_valid = pressure_valid;
  assign t_if.new_value = temperature_measured;
  assign t_if.new_valid = temperature_valid;

  // side effects of reads land once, in the request cycle before ack
  assign p_if.rd_low = rd && idx == BRO_IDX_PRESS_LO;
  assign p_if.rd_top = rd && idx == BRO_IDX_PRESS_HI;
  assign t_if.rd_low = rd && idx == BRO_IDX_TEMP_LO;
  assign t_if.rd_top = rd && idx == BRO_IDX_TEMP_HI;

  // ****************************************************************
  // status and interrupt
  // ****************************************************************
  logic [7:0] status;
  logic [7:0] events;
  logic [7:0] irq_stat_q, irq_stat_d;
  logic [7:0] irq_mask_q, irq_mask_d;
  logic irq_q, irq_d;

  always_comb begin
    status = 8'h00;
    status[BRO_BIT_P_AVAIL] = p_if.available;
    status[BRO_BIT_T_AVAIL] = t_if.available;
    status[BRO_BIT_P_OVR] = p_if.overrun;
    status[BRO_BIT_T_OVR] = t_if.overrun;
    events = 8'h00;
    events[BRO_BIT_P_AVAIL] = pressure_valid;
    events[BRO_BIT_T_AVAIL] = temperature_valid;
    events[BRO_BIT_P_OVR] = pressure_valid & p_if.available;
    events[BRO_BIT_T_OVR] = temperature_valid & t_if.available;
  end

  always_comb begin
    irq_stat_d = irq_stat_q;
    irq_mask_d = irq_mask_q;
    if (rd && idx == BRO_IDX_IRQ_STAT) begin
      irq_stat_d = 8'h00;
    end
    // an event in the clearing cycle is kept
    irq_stat_d = irq_stat_d | events;
    if (wr && idx == BRO_IDX_IRQ_MASK) begin
      irq_mask_d = wb_dat_i[7:0];
    end
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_q <= BRO_RST_BYTE;
      irq_mask_q <= BRO_RST_BYTE;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
    end
  end

  // ****************************************************************
  // read mux, strobes and bus answer
  // ****************************************************************
  logic pop_q, pop_d;
  logic lpf_q, lpf_d;
  logic [7:0] rbyte;

  always_comb begin
    rbyte = 8'h00;
    case (idx)
      BRO_IDX_OFFS_LO: rbyte = offs_lo_q;
      BRO_IDX_OFFS_HI: rbyte = offs_hi_q;
      BRO_IDX_STATUS: rbyte = status;
      BRO_IDX_PRESS_LO: rbyte = p_if.result[7:0];
      BRO_IDX_PRESS_MID: rbyte = p_if.result[15:8];
      BRO_IDX_PRESS_HI: rbyte = p_if.result[23:16];
      BRO_IDX_TEMP_LO: rbyte = t_if.result[7:0];
      BRO_IDX_TEMP_HI: rbyte = t_if.result[15:8];
      BRO_IDX_MODE: rbyte = {5'h00, mode_q};
      BRO_IDX_IRQ_STAT: rbyte = irq_stat_q;
      BRO_IDX_IRQ_MASK: rbyte = irq_mask_q;
      BRO_IDX_QP_LO: rbyte = queue_pressure[7:0];
      BRO_IDX_QP_MID: rbyte = queue_pressure[15:8];
      BRO_IDX_QP_HI: rbyte = queue_pressure[23:16];
      BRO_IDX_QT_LO: rbyte = queue_temperature[7:0];
      BRO_IDX_QT_HI: rbyte = queue_temperature[15:8];
      default: rbyte = 8'h00;
    endcase
  end

  always_comb begin
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    rdat_d = BRO_RST_WORD;
    if (rd) begin
      rdat_d = {24'h000000, rbyte};
    end
    // writes to result, status and queue indices fall through untouched
    lpf_d = rd && idx == BRO_IDX_LPF_RES;
    // the queue advances only once its last byte has been read
    pop_d = rd && idx == BRO_IDX_QT_HI && queue_not_empty;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      rdat_q <= BRO_RST_WORD;
      lpf_q <= 1'b0;
      pop_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      lpf_q <= lpf_d;
      pop_q <= pop_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign filter_reset = lpf_q;
  assign queue_pop = pop_q;
  assign irq = irq_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_T_OVERRUN: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (temperature_valid && t_if.available) |=> t_if.overrun)
    else $error("temperature overrun not set");

  AST_P_OVERRUN: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (pressure_valid && p_if.available) |=> p_if.overrun)
    else $error("pressure overrun not set");

  AST_T_AVAIL: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    temperature_valid |=> t_if.available ##0 status[BRO_BIT_T_AVAIL])
    else $error("temperature available not set");

  AST_P_AVAIL: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    pressure_valid |=> status[BRO_BIT_P_AVAIL])
    else $error("pressure available not set");

  AST_STATUS_READ: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (rd && idx == BRO_IDX_STATUS)
      |=> wb_ack_o && wb_dat_o[7:0] == $past(status))
    else $error("status read returned wrong value");

  AST_PRESS_HIGH: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (rd && idx == BRO_IDX_PRESS_HI)
      |=> wb_dat_o == {24'h000000, $past(p_if.result[23:16])})
    else $error("pressure high byte wrong");

  AST_PRESS_CAL: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (pressure_valid && modes_off && !p_if.locked && !p_if.rd_low)
      |=> p_if.result == $past(pressure_measured - offset_ext))
    else $error("pressure not offset-corrected");

  AST_TEMP_LOW: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (rd && idx == BRO_IDX_TEMP_LO)
      |=> wb_dat_o[7:0] == $past(t_if.result[7:0]))
    else $error("temperature low byte wrong");

  AST_FILTER_RESET: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (rd && idx == BRO_IDX_LPF_RES) |=> filter_reset ##1 !filter_reset)
    else $error("filter reset strobe missing");

  AST_QUEUE_PRESS: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (rd && idx == BRO_IDX_QP_MID)
      |=> wb_dat_o[7:0] == $past(queue_pressure[15:8]))
    else $error("queued pressure byte wrong");

  AST_QUEUE_POP: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (rd && idx == BRO_IDX_QT_HI && queue_not_empty)
      |=> queue_pop && wb_dat_o[7:0] == $past(queue_temperature[15:8]))
    else $error("queued temperature read wrong");

  AST_WRITE_IGNORED: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (wr && idx == BRO_IDX_PRESS_LO && !pressure_valid && !p_if.locked)
      |=> $stable(p_if.result) && $stable(p_if.available))
    else $error("write changed a read-only result");

  AST_READ_CLEARS: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (rd && idx == BRO_IDX_PRESS_HI && !pressure_valid)
      |=> !p_if.available && !p_if.overrun)
    else $error("pressure flags not cleared by read");

  COV_P_OVERRUN: cover property (
    @(posedge sys_clk) disable iff (!rst_b)
    pressure_valid ##[1:20] (pressure_valid && p_if.available));

  COV_COHERENT_READ: cover property (
    @(posedge sys_clk) disable iff (!rst_b)
    p_if.rd_low ##[1:10] pressure_valid ##[1:10] p_if.rd_top);

  COV_FILTER_RESET: cover property (
    @(posedge sys_clk) disable iff (!rst_b)
    filter_reset);

  COV_IRQ: cover property (
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(irq));

endmodule : bro_readout

// [bro_result_slot.sv]
/*
  One result channel: newest value, a snapshot frozen during a multi-byte
  read, and the available / overrun flags.
  Assumes rd_low and rd_top are single-cycle pulses from the bus logic.
*/
module bro_result_slot
  import bro_pkg::*;
#(
  parameter int W = 24
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  bro_slot_if.slot port
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [W-1:0] value_q, value_d;
  logic [W-1:0] snap_q, snap_d;
  logic avail_q, avail_d;
  logic ovr_q, ovr_d;
  logic lock_q, lock_d;

  always_comb begin
    value_d = value_q;
    avail_d = avail_q;
    ovr_d = ovr_q;
    lock_d = lock_q;
    // a completed read clears the flags; fresh data below wins
    if (port.rd_top) begin
      avail_d = 1'b0;
      ovr_d = 1'b0;
      lock_d = 1'b0;
    end else if (port.rd_low) begin
      lock_d = 1'b1;
    end
    if (port.new_valid) begin
      value_d = port.new_value;
      avail_d = 1'b1;
      ovr_d = ovr_q | avail_q;
    end
    // the snapshot stays frozen while a read is in progress; a first-byte
    // read freezes the very value it returns, even beside fresh data
    if (lock_q || port.rd_low) begin
      snap_d = snap_q;
    end else if (port.new_valid) begin
      snap_d = port.new_value;
    end else begin
      snap_d = value_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      value_q <= '0;
      snap_q <= '0;
      avail_q <= 1'b0;
      ovr_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      value_q <= value_d;
      snap_q <= snap_d;
      avail_q <= avail_d;
      ovr_q <= ovr_d;
      lock_q <= lock_d;
    end
  end

  assign port.result = snap_q;
  assign port.available = avail_q;
  assign port.overrun = ovr_q;
  assign port.locked = lock_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_SLOT_FROZEN: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (lock_q && !port.rd_top) |=> $stable(snap_q))
    else $error("snapshot changed during a multi-byte read");

endmodule : bro_result_slot

// [bro_sensor_model.sv]
/*
  Sensor front-end model for the barometer readout: conversion strobes
  and a sample queue that the readout pops.
  Assumes one clock shared with the readout; driven by tasks of the bench.
*/
module bro_sensor_model
  import bro_pkg::*;
(
  input wire logic sys_clk,
  input wire logic queue_pop,
  output logic [23:0] pressure_measured,
  output logic pressure_valid,
  output logic [15:0] temperature_measured,
  output logic temperature_valid,
  output logic [23:0] queue_pressure,
  output logic [15:0] queue_temperature,
  output logic queue_not_empty
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [39:0] fifo_q[$];

  initial begin
    pressure_measured = 24'h000000;
    pressure_valid = 1'b0;
    temperature_measured = 16'h0000;
    temperature_valid = 1'b0;
    queue_pressure = 24'h000000;
    queue_temperature = 16'h0000;
    queue_not_empty = 1'b0;
  end

  // both channels convert together, strobed for a single cycle
  task automatic convert(input logic [23:0] p, input logic [15:0] t);
    @(posedge sys_clk);
    pressure_measured <= p;
    temperature_measured <= t;
    pressure_valid <= 1'b1;
    temperature_valid <= 1'b1;
    @(posedge sys_clk);
    pressure_valid <= 1'b0;
    temperature_valid <= 1'b0;
    // lines are stale after the strobe: show a different value
    pressure_measured <= ~p;
    temperature_measured <= ~t;
  endtask : convert

  task automatic push(input logic [23:0] p, input logic [15:0] t);
    fifo_q.push_back({p, t});
  endtask : push

  // an empty queue shows changing data so a stale sample is never trusted
  always @(posedge sys_clk) begin
    if (queue_pop && fifo_q.size() > 0) begin
      void'(fifo_q.pop_front());
    end
    if (fifo_q.size() > 0) begin
      {queue_pressure, queue_temperature} <= fifo_q[0];
      queue_not_empty <= 1'b1;
    end else begin
      queue_pressure <= ~queue_pressure;
      queue_temperature <= ~queue_temperature;
      queue_not_empty <= 1'b0;
    end
  end
endmodule : bro_sensor_model

// [bro_slot_if.sv]
/*
  Carrier between the readout core and one result slot.
  Assumes both ends run on the same clock.
*/
interface bro_slot_if #(parameter int W = 24);
  logic [W-1:0] new_value;
  logic new_valid;
  logic rd_low;
  logic rd_top;
  logic [W-1:0] result;
  logic available;
  logic overrun;
  logic locked;

  modport core (
    output new_value,
    output new_valid,
    output rd_low,
    output rd_top,
    input result,
    input available,
    input overrun,
    input locked
  );

  modport slot (
    input new_value,
    input new_valid,
    input rd_low,
    input rd_top,
    output result,
    output available,
    output overrun,
    output locked
  );
endinterface : bro_slot_if

// [tb_top.sv]
/*
  Self-checking bench of the barometer result readout.
  Assumes bro_readout, bro_pkg and the sensor model are compiled before it.
*/
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module tb_top
  import bro_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic rst_b;
  logic wb_cyc_i, wb_stb_i, wb_we_i;
  logic [8:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic wb_ack_o, queue_pop, filter_reset, irq;
  logic [23:0] pressure_measured, queue_pressure;
  logic [15:0] temperature_measured, queue_temperature;
  logic pressure_valid, temperature_valid, queue_not_empty;
  logic fr_seen, qp_seen;
  int bad_count = 0;
  int comparisons = 0;

  bro_readout i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pressure_measured(pressure_measured), .pressure_valid(pressure_valid),
    .temperature_measured(temperature_measured),
    .temperature_valid(temperature_valid), .queue_pressure(queue_pressure),
    .queue_temperature(queue_temperature),
    .queue_not_empty(queue_not_empty), .queue_pop(queue_pop),
    .filter_reset(filter_reset), .irq(irq));

  bro_sensor_model i_sens (.sys_clk(sys_clk), .queue_pop(queue_pop),
    .pressure_measured(pressure_measured), .pressure_valid(pressure_valid),
    .temperature_measured(temperature_measured),
    .temperature_valid(temperature_valid), .queue_pressure(queue_pressure),
    .queue_temperature(queue_temperature),
    .queue_not_empty(queue_not_empty));

  always #10ns sys_clk = ~sys_clk;

  // ****************************************************************
  // bus access
  // ****************************************************************
  task automatic bus(input logic we, input logic [6:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h000000, wd};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    fr_seen = filter_reset;
    qp_seen = queue_pop;
    `CHK("ack latency", 2, n)
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [6:0] idx, input logic [7:0] e);
    logic [7:0] v;
    bus(1'b0, idx, 8'h00, v);
    `CHK($sformatf("reg %h", idx), e, v)
  endtask : rd_chk

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [7:0] v;
    bus(1'b1, idx, d, v);
  endtask : wr

  task automatic rd_p(input logic [23:0] e);
    rd_chk(BRO_IDX_PRESS_LO, e[7:0]);
    rd_chk(BRO_IDX_PRESS_MID, e[15:8]);
    rd_chk(BRO_IDX_PRESS_HI, e[23:16]);
  endtask : rd_p

  task automatic rd_q(input logic [23:0] p, input logic [15:0] t);
    rd_chk(BRO_IDX_QP_LO, p[7:0]);
    rd_chk(BRO_IDX_QP_MID, p[15:8]);
    rd_chk(BRO_IDX_QP_HI, p[23:16]);
    rd_chk(BRO_IDX_QT_LO, t[7:0]);
    rd_chk(BRO_IDX_QT_HI, t[15:8]);
    `CHK("queue pop", 1'b1, qp_seen)
  endtask : rd_q

  function automatic logic [23:0] exp_p(input logic [23:0] p,
                                        input logic [15:0] off);
    return p - {{8{off[15]}}, off};
  endfunction : exp_p

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd_chk(BRO_IDX_STATUS, 8'h00);
    rd_chk(BRO_IDX_OFFS_HI, 8'h00);
    rd_chk(BRO_IDX_IRQ_MASK, 8'h00);
    `CHK("irq", 1'b0, irq)
  endtask : t_reset

  task automatic t_fresh();
    i_sens.convert(24'h812345, 16'hF00D);
    rd_chk(BRO_IDX_STATUS, 8'h03);
    rd_chk(BRO_IDX_PRESS_LO, 8'h45);
    rd_chk(BRO_IDX_PRESS_MID, 8'h23);
    rd_chk(BRO_IDX_STATUS, 8'h03);
    rd_chk(BRO_IDX_PRESS_HI, 8'h81);
    rd_chk(BRO_IDX_STATUS, 8'h02);
    rd_chk(BRO_IDX_TEMP_LO, 8'h0D);
    rd_chk(BRO_IDX_TEMP_HI, 8'hF0);
    rd_chk(BRO_IDX_STATUS, 8'h00);
  endtask : t_fresh

  task automatic t_overrun();
    i_sens.convert(24'h110100, 16'h1100);
    i_sens.convert(24'h220200, 16'h3300);
    rd_chk(BRO_IDX_STATUS, 8'h33);
    rd_chk(BRO_IDX_PRESS_HI, 8'h22);
    rd_chk(BRO_IDX_TEMP_HI, 8'h33);
    rd_chk(BRO_IDX_STATUS, 8'h00);
  endtask : t_overrun

  task automatic t_coherent();
    i_sens.convert(24'hAABBCC, 16'h1234);
    rd_chk(BRO_IDX_PRESS_LO, 8'hCC);
    i_sens.convert(24'h556677, 16'h5678);
    rd_chk(BRO_IDX_PRESS_MID, 8'hBB);
    rd_chk(BRO_IDX_PRESS_HI, 8'hAA);
    rd_chk(BRO_IDX_STATUS, 8'h22);
    rd_chk(BRO_IDX_TEMP_HI, 8'h56);
    rd_chk(BRO_IDX_STATUS, 8'h00);
  endtask : t_coherent

  task automatic t_offset();
    wr(BRO_IDX_OFFS_LO, 8'h38);
    wr(BRO_IDX_OFFS_HI, 8'hFF);
    rd_chk(BRO_IDX_OFFS_LO, 8'h38);
    rd_chk(BRO_IDX_OFFS_HI, 8'hFF);
    i_sens.convert(24'h001000, 16'h0000);
    rd_p(exp_p(24'h001000, 16'hFF38));
    wr(BRO_IDX_OFFS_HI, 8'h00);
    i_sens.convert(24'h000010, 16'h0000);
    rd_p(exp_p(24'h000010, 16'h0038));
    // with a mode bit set the raw value passes through
    wr(BRO_IDX_MODE, 8'h01);
    i_sens.convert(24'h002000, 16'h0000);
    rd_p(24'h002000);
    // the other two mode bits must bypass the offset as well
    wr(BRO_IDX_MODE, 8'h06);
    rd_chk(BRO_IDX_MODE, 8'h06);
    i_sens.convert(24'h001000, 16'h0000);
    rd_p(24'h001000);
    wr(BRO_IDX_MODE, 8'h00);
    wr(BRO_IDX_OFFS_LO, 8'h00);
    rd_chk(BRO_IDX_TEMP_HI, 8'h00);
    rd_chk(BRO_IDX_STATUS, 8'h00);
  endtask : t_offset

  task automatic t_ro();
    wr(BRO_IDX_STATUS, 8'hFF);
    wr(BRO_IDX_PRESS_LO, 8'hAA);
    wr(BRO_IDX_TEMP_HI, 8'h55);
    wr(BRO_IDX_QT_LO, 8'h11);
    wr(7'h50, 8'hFF);
    rd_chk(BRO_IDX_STATUS, 8'h00);
    rd_p(24'h001000);
    rd_chk(BRO_IDX_TEMP_HI, 8'h00);
    rd_chk(7'h50, 8'h00);
  endtask : t_ro

  task automatic t_filter();
    logic [7:0] v;
    bus(1'b0, BRO_IDX_LPF_RES, 8'h00, v);
    `CHK("filter reset", 1'b1, fr_seen)
    rd_chk(BRO_IDX_STATUS, 8'h00);
    `CHK("filter idle", 1'b0, fr_seen)
  endtask : t_filter

  task automatic t_queue();
    logic [7:0] v;
    i_sens.push(24'hA1B2C3, 16'hD4E5);
    i_sens.push(24'h102030, 16'h4050);
    repeat (2) @(posedge sys_clk);
    rd_q(24'hA1B2C3, 16'hD4E5);
    rd_q(24'h102030, 16'h4050);
    bus(1'b0, BRO_IDX_QT_HI, 8'h00, v);
    `CHK("pop when empty", 1'b0, qp_seen)
  endtask : t_queue

  task automatic t_irq();
    logic [7:0] v;
    bus(1'b0, BRO_IDX_IRQ_STAT, 8'h00, v);
    wr(BRO_IDX_IRQ_MASK, 8'h01);
    i_sens.convert(24'h000001, 16'h0001);
    repeat (3) @(posedge sys_clk);
    `CHK("irq new data", 1'b1, irq)
    rd_chk(BRO_IDX_IRQ_STAT, 8'h03);
    repeat (3) @(posedge sys_clk);
    `CHK("irq cleared", 1'b0, irq)
    wr(BRO_IDX_IRQ_MASK, 8'h10);
    rd_chk(BRO_IDX_IRQ_MASK, 8'h10);
    i_sens.convert(24'h000002, 16'h0002);
    repeat (3) @(posedge sys_clk);
    `CHK("irq overrun", 1'b1, irq)
    rd_chk(BRO_IDX_IRQ_STAT, 8'h33);
    repeat (3) @(posedge sys_clk);
    `CHK("irq cleared", 1'b0, irq)
    wr(BRO_IDX_IRQ_MASK, 8'h00);
  endtask : t_irq

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    rst_b = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 9'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_filter();
    t_fresh();
    t_overrun();
    t_coherent();
    t_offset();
    t_ro();
    t_queue();
    t_irq();
    results();
  end

  // the whole run needs a few hundred clock cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    $display("[FAIL] watchdog exp done got hang");
    results();
  end
endmodule : tb_top
